// *** hw/wdt_osc_div.sv ***
/*
 * Watchdog oscillator stand-in: divides the system clock to a 1 MHz tick.
 * Assumes one system clock; the tick is a one-cycle enable pulse.
 */
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_osc_div
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// tick out
	output logic      tick_o
);

	localparam logic [4:0] DIV_LAST = 5'(`WDT_OSC_DIV - 1);

	logic [4:0] div_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 5'h00;
			tick_o  <= 1'b0;
		end else begin
			tick_o  <= (div_reg == DIV_LAST);
			div_reg <= (div_reg == DIV_LAST) ? 5'h00 : div_reg + 5'h01;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_tick_spacing: assert property (tick_o |=> !tick_o [*8])
		else $error("watchdog tick repeats too soon");

endmodule

// *** hw/wdt_params.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the watchdog.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register byte offsets on the wishbone bus
`define WDT_OFS_CTRL     8'h00
`define WDT_OFS_STAT     8'h04

// control field positions
`define WDT_BIT_UNLOCK   4
`define WDT_BIT_ON       3
`define WDT_PER_MSB      2
`define WDT_PER_LSB      0
`define WDT_RSV_MSB      7
`define WDT_RSV_LSB      5

// status field positions
`define WDT_BIT_TOFLAG   3

// reset values
`define WDT_CTRL_RST     8'h00

// timing
`define WDT_CLK_HZ       25000000
`define WDT_OSC_HZ       1000000
`define WDT_OSC_DIV      (`WDT_CLK_HZ / `WDT_OSC_HZ)
`define WDT_UNLOCK_CYC   3'h4
`define WDT_BASE_TICKS   16384

`endif

// *** hw/wdt_pkg.sv ***
/*
 * Types shared by the watchdog design files.
 * Assumes wdt_params.svh is on the include path.
 */
`include "wdt_params.svh"

package wdt_pkg;

	typedef logic [2:0]  wdt_period_t;
	typedef logic [21:0] wdt_count_t;

	typedef enum logic [1:0] {
		WDT_SEL_CTRL = 2'b00,
		WDT_SEL_STAT = 2'b01,
		WDT_SEL_NONE = 2'b10
	} wdt_regsel_e;

endpackage

// *** hw/wdt_top.sv ***
/*
 * Watchdog timer with protected turn-off, classic wishbone slave.
 * Assumes rst_i is the power-on reset, sys_reset_i any other chip reset,
 * restart_i a one-cycle pulse from the restart instruction.
 */
// The register addresses and the Wishbone register port were left to the implementer.
// Function
// - counter ticks from dedicated 1 MHz oscillator; here a 1 MHz tick divided down from the system clock
// - restart instruction clears the count
// - disable or chip reset clears count
// - expiry while enabled resets the chip
// - period select doubles 16384 per code
// - top three control bits read zero
// - enable bit one on, zero off
// - zero accepted only while unlock reads one
// - unlock clears itself four cycles later
// - one-cycle reset pulse on timeout
// - timeout flag set, cleared by por/zero
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top
	import wdt_pkg::*;
#(
	parameter int BASE_TICKS = `WDT_BASE_TICKS
)(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sys_reset_i,
	// cpu events
	input  wire logic        restart_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// reset request to chip and enable status
	output logic             chip_reset_o,
	output logic             watchdog_on_o
);

	localparam logic [7:0] CTRL_RST = `WDT_CTRL_RST;

	logic        unlock_reg;
	logic        on_reg;
	wdt_period_t period_reg;
	logic [2:0]  win_reg;
	wdt_count_t  count_reg;
	logic        flag_reg;
	logic        tick;
	logic        access;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        timeout;
	wdt_count_t  limit;

	function automatic wdt_regsel_e decode(input logic [7:0] adr);
		if (adr == `WDT_OFS_CTRL)
			return WDT_SEL_CTRL;
		else if (adr == `WDT_OFS_STAT)
			return WDT_SEL_STAT;
		else
			return WDT_SEL_NONE;
	endfunction

	function automatic wdt_count_t period_limit(input wdt_period_t sel);
		return wdt_count_t'(BASE_TICKS) << sel;
	endfunction

	wdt_osc_div u_osc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	// write lands on the edge where ack is seen high
	assign access  = wb_cyc_i & wb_stb_i & wb_ack_o;
	assign wr_ctrl = access & wb_we_i & wb_sel_i[0] & (decode(wb_adr_i) == WDT_SEL_CTRL);
	assign wr_stat = access & wb_we_i & wb_sel_i[0] & (decode(wb_adr_i) == WDT_SEL_STAT);
	assign limit   = period_limit(period_reg);
	assign timeout = tick & on_reg & (count_reg >= limit - 22'h1);

	// bus handshake: ack one cycle after strobe, drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			unique case (decode(wb_adr_i))
				WDT_SEL_CTRL: wb_dat_o[7:0] <= {3'h0, unlock_reg, on_reg, period_reg};
				WDT_SEL_STAT: wb_dat_o[`WDT_BIT_TOFLAG] <= flag_reg;
				WDT_SEL_NONE: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// control register; own timeout acts as a chip reset
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_reset_i || chip_reset_o) begin
			on_reg     <= CTRL_RST[`WDT_BIT_ON];
			period_reg <= CTRL_RST[`WDT_PER_MSB:`WDT_PER_LSB];
		end else if (wr_ctrl) begin
			period_reg <= wb_dat_i[`WDT_PER_MSB:`WDT_PER_LSB];
			if (wb_dat_i[`WDT_BIT_ON])
				on_reg <= 1'b1;
			else if (unlock_reg)
				on_reg <= 1'b0;
		end
	end

	// unlock window counted on the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_reset_i || chip_reset_o) begin
			unlock_reg <= 1'b0;
			win_reg    <= 3'h0;
		end else if (wr_ctrl && wb_dat_i[`WDT_BIT_UNLOCK] && wb_dat_i[`WDT_BIT_ON]
			&& !unlock_reg) begin
			unlock_reg <= 1'b1;
			win_reg    <= `WDT_UNLOCK_CYC;
		end else if (unlock_reg) begin
			win_reg <= win_reg - 3'h1;
			if (win_reg == 3'h1)
				unlock_reg <= 1'b0;
		end
	end

	// counter on the oscillator tick; restart and timeout clear it in the same clock, a tick in that clock is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_reset_i || chip_reset_o || !on_reg)
			count_reg <= 22'h0;
		else if (restart_i)
			count_reg <= 22'h0;
		else if (timeout)
			count_reg <= 22'h0;
		else if (tick)
			count_reg <= count_reg + 22'h1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			chip_reset_o <= 1'b0;
		else
			chip_reset_o <= timeout & ~restart_i & ~sys_reset_i & ~chip_reset_o;
	end

	// timeout flag survives the chip reset; set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_reg <= 1'b0;
		else if (timeout && !restart_i && !sys_reset_i && !chip_reset_o)
			flag_reg <= 1'b1;
		else if (wr_stat && !wb_dat_i[`WDT_BIT_TOFLAG])
			flag_reg <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			watchdog_on_o <= 1'b0;
		else
			watchdog_on_o <= on_reg;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_unlock_hold;
		unlock_reg [*4] ##1 !unlock_reg;
	endsequence

	a_unlock_expiry: assert property (disable iff (rst_i || sys_reset_i || chip_reset_o)
		$rose(unlock_reg) |-> s_unlock_hold)
		else $error("unlock bit did not clear after four cycles");
	a_unlock_window: assert property ($rose(unlock_reg) |-> win_reg == 3'h4)
		else $error("unlock window not loaded with four");
	a_off_locked: assert property (wr_ctrl && !wb_dat_i[`WDT_BIT_ON] && !unlock_reg
		&& on_reg && !sys_reset_i && !chip_reset_o |=> on_reg)
		else $error("watchdog turned off without unlock");
	a_on_write: assert property (wr_ctrl && wb_dat_i[`WDT_BIT_ON] && !sys_reset_i
		&& !chip_reset_o |=> on_reg)
		else $error("enable write ignored");
	a_restart_clear: assert property (restart_i |=> count_reg == 22'h0)
		else $error("restart did not clear count");
	a_disable_clear: assert property (!on_reg |=> count_reg == 22'h0)
		else $error("count not cleared while disabled");
	a_timeout_pulse: assert property (tick && on_reg && count_reg == limit - 22'h1
		&& !restart_i && !sys_reset_i && !chip_reset_o
		|=> chip_reset_o ##1 !chip_reset_o)
		else $error("timeout pulse missing or too long");
	a_flag_follows: assert property (chip_reset_o |-> flag_reg)
		else $error("timeout flag not set");
	a_reserved_zero: assert property (wb_dat_o[`WDT_RSV_MSB:`WDT_RSV_LSB] == 3'h0)
		else $error("reserved bits read nonzero");
	a_timeout_reset: assert property (chip_reset_o |=> !on_reg && count_reg == 22'h0)
		else $error("timeout did not reset watchdog");

	// counter moves only on the tick, flag stays until cleared
	a_count_step: assert property (tick && on_reg && !timeout && !restart_i
		&& !sys_reset_i && !chip_reset_o |=> count_reg == $past(count_reg) + 22'h1)
		else $error("count did not step on the tick");
	a_count_idle: assert property (!tick && on_reg && !restart_i && !sys_reset_i
		&& !chip_reset_o |=> $stable(count_reg))
		else $error("count moved without a tick");
	a_timeout_late: assert property (chip_reset_o
		|-> $past(count_reg) >= $past(limit) - 22'h1)
		else $error("timeout before the selected period");
	a_pulse_single: assert property (chip_reset_o |=> !chip_reset_o)
		else $error("chip reset pulse longer than one cycle");
	a_flag_sticky: assert property (flag_reg
		&& !(wr_stat && !wb_dat_i[`WDT_BIT_TOFLAG]) |=> flag_reg)
		else $error("timeout flag lost");
	a_sys_reset_clear: assert property (sys_reset_i
		|=> !on_reg && !unlock_reg && count_reg == 22'h0)
		else $error("chip reset left watchdog state");

endmodule

// *** testbench/tb_top.sv ***
/* Self-checking bench for the watchdog: register access, protected turn-off,
   restart and timeout for every period code.
   Assumes wdt_top with BASE_TICKS cut to 4 and a 25 MHz clock. */
`timescale 1ns/1ps
module tb_top;
	logic        clk_i, rst_i, sys_reset_i, restart_i;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        chip_reset_o, watchdog_on_o;
	int          mismatches, comparisons, n, gap;
	localparam int BT = 4;

	wdt_top #(.BASE_TICKS(BT)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i), .restart_i(restart_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chip_reset_o(chip_reset_o), .watchdog_on_o(watchdog_on_o));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 20) begin
			mismatches++;
			stop_test();
		end
	endtask

	initial begin
		rst_i = 1'b1; sys_reset_i = 1'b0; restart_i = 1'b0; wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h1;
		wb_dat_i = 32'h00000000;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		void'($urandom(89891));
		wb(0, 8'h00, 8'h00); chk(q, 32'h00);
		wb(0, 8'h04, 8'h00); chk(q, 32'h00);
		wb(1, 8'h00, 8'he8); wb(0, 8'h00, 8'h00); chk(q, 32'h08);
		chk(watchdog_on_o, 1);
		wb(1, 8'h00, 8'h00); wb(0, 8'h00, 8'h00); chk(q, 32'h08);
		wb(1, 8'h00, 8'h18); repeat (6) @(posedge clk_i);
		wb(0, 8'h00, 8'h00); chk(q, 32'h08);
		wb(1, 8'h00, 8'h00); wb(0, 8'h00, 8'h00); chk(q, 32'h08);
		restart_i <= 1'b1;
		@(posedge clk_i);
		restart_i <= 1'b0;
		wb(1, 8'h00, 8'h18);
		wb(1, 8'h00, 8'h00);
		wb(0, 8'h00, 8'h00); chk(q, 32'h00);
		$display("test control done");
		wb(1, 8'h00, 8'h0b); sys_reset_i <= 1'b1; @(posedge clk_i); sys_reset_i <= 1'b0;
		wb(0, 8'h00, 8'h00); chk(q, 32'h00);
		wb(1, 8'h00, 8'h08);
		n = 0; gap = 10 + $urandom % 60;
		for (int i = 0; i < 700; i++) begin
			@(posedge clk_i);
			n += (chip_reset_o === 1'b1);
			gap--;
			restart_i <= (gap == 0);
			if (gap == 0) gap = 10 + $urandom % 60;
		end
		@(posedge clk_i);
		restart_i <= 1'b1;
		@(posedge clk_i);
		restart_i <= 1'b0;
		chk(n, 0);
		wb(1, 8'h00, 8'h18);
		wb(1, 8'h00, 8'h00);
		$display("test restart done");
		for (int p = 0; p < 8; p++) begin
			wb(1, 8'h00, 8'h08 | p[7:0]);
			@(posedge clk_i); restart_i <= 1'b1; @(posedge clk_i); restart_i <= 1'b0;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (chip_reset_o !== 1'b1 && n < 15000);
			if (n >= 15000) begin
				mismatches++;
				stop_test();
			end
			chk((n - 2) / 25, (BT << p) - 1);
			@(posedge clk_i); chk(chip_reset_o, 0);
			wb(0, 8'h04, 8'h00); chk(q, 32'h08);
			wb(0, 8'h00, 8'h00); chk(q, 32'h00);
			wb(1, 8'h04, 8'h00); wb(0, 8'h04, 8'h00); chk(q, 32'h00);
		end
		$display("test timeout done");
		stop_test();
	end
endmodule
